// File: hw/nfctx_pkg.sv
package nfctx_pkg;

   // register indices; the byte address is four times the index
   localparam logic [7:0] IDX_TX_FRAME_CONFIG      = 8'h18;
   localparam logic [7:0] IDX_TX_CHECKSUM_CONFIG   = 8'h19;
   localparam logic [7:0] IDX_RECEIVE_RATE_CONFIG  = 8'h1a;
   localparam logic [7:0] IDX_FRAME_CONTROL        = 8'h20;

   // tx_frame_config fields
   localparam int TFC_FINAL_PARITY_INVERT = 13;
   localparam int TFC_PARITY_TYPE         = 12;
   localparam int TFC_PARITY_ENABLE       = 11;
   localparam int TFC_DATA_ENABLE         = 10;
   localparam int TFC_STOP_LSB            = 8;
   localparam int TFC_START_LSB           = 6;
   localparam int TFC_LAST_BITS_LSB       = 3;
   localparam int TFC_FIRST_BITS_LSB      = 0;
   localparam int TFC_WIDTH               = 14;
   localparam logic [13:0] TFC_RESET      = 14'h0000;

   // tx_checksum_config fields
   localparam int TCC_PRESET_VALUE_LSB    = 16;
   localparam int TCC_SKIP_FIRST_BYTE     = 6;
   localparam int TCC_PRESET_SEL_LSB      = 3;
   localparam int TCC_SHORT_TYPE          = 2;
   localparam int TCC_COMPLEMENT          = 1;
   localparam int TCC_ENABLE              = 0;
   localparam logic [31:0] TCC_RESET      = 32'h0000_0000;
   localparam logic [31:0] TCC_WMASK      = 32'hffff_007f;

   // checksum presets
   localparam logic [15:0] CRC_PRESET_0   = 16'h0000;
   localparam logic [15:0] CRC_PRESET_1   = 16'h6363;
   localparam logic [15:0] CRC_PRESET_2   = 16'ha671;
   localparam logic [15:0] CRC_PRESET_3   = 16'hffff;
   localparam logic [15:0] CRC_PRESET_4   = 16'h0012;
   localparam logic [15:0] CRC_PRESET_5   = 16'he012;
   localparam logic [15:0] CRC_POLY16     = 16'h8408;
   localparam logic [4:0]  CRC_POLY5      = 5'h12;
   localparam logic [4:0]  CRC_LEN16      = 5'h10;
   localparam logic [4:0]  CRC_LEN5       = 5'h05;

   // receive_rate_config
   localparam logic [2:0] RATE_RESET      = 3'h0;

   // frame_control fields
   localparam int FCT_GO                  = 0;
   localparam int FCT_BUSY                = 1;
   localparam int FCT_NO_DATA_ERR         = 2;
   localparam int FCT_COUNT_LSB           = 16;
   localparam logic [8:0] FCT_COUNT_RESET = 9'h000;

   localparam int BIT_DIV_DEFAULT         = 8;

   typedef enum logic [2:0] {
      ST_IDLE, ST_START, ST_LOAD, ST_DATA, ST_PARITY, ST_CRC, ST_STOP, ST_DONE
   } nfctx_state_type;

endpackage

// File: hw/nfctx_encoder.sv
// Register access over APB is this design's own decision.
`timescale 1ns/1ps

//Contract
//R1: invert parity of final data byte when set
//R2: parity type zero even, one odd
//R3: append parity bit after each data byte
//R4: data enabled with zero count flags error
//R5: data enable sends bytes, else symbols only
//R6: stop field picks none, symbol 1-3
//R7: start field picks none, symbol 0-2
//R8: last-bits count trims end of final byte
//R9: first-bits count trims start of first byte
//R10: sixteen-bit programmable checksum preset value
//R11: skip-first-byte starts checksum at second byte
//R12: preset selector loads fixed or programmed value
//R13: short checksum uses preset low byte only
//R14: type zero sixteen-bit, one five-bit checksum
//R15: complement control inverts transmitted checksum
//R16: checksum enable computes and appends checksum
//R17: receive rate field selects baud rate
//R18: rate msb ignored outside reader mode
//R19: mode detector writes receive rate field
//R20: order start, data with parity, checksum, stop
//R21: reserved bits read zero, ignore writes
module nfctx_encoder
   import nfctx_pkg::*;
#(
   parameter int BIT_DIV   = BIT_DIV_DEFAULT,
   parameter int CNT_WIDTH = 9
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [7:0]  data_byte,
   input  wire logic        data_valid,
   output logic             data_ready,
   output logic             enc_bit,
   output logic             enc_bit_valid,
   output logic [1:0]       enc_symbol,
   output logic             enc_symbol_valid,
   output logic             frame_done,
   input  wire logic        reader_mode,
   input  wire logic        mode_detect_enable,
   input  wire logic        mode_detect_valid,
   input  wire logic [2:0]  mode_detect_rate,
   output logic [2:0]       receive_rate_active
);

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic [15:0] preset_of(input logic [2:0] sel, input logic [15:0] prog);
      logic [15:0] v;
      v = CRC_PRESET_0;
      case (sel)
         3'h1: v = CRC_PRESET_1;
         3'h2: v = CRC_PRESET_2;
         3'h3: v = CRC_PRESET_3;
         3'h4: v = CRC_PRESET_4;
         3'h5: v = CRC_PRESET_5;
         3'h7: v = prog;
         default: v = CRC_PRESET_0;
      endcase
      return v;
   endfunction

   // lsb-first shift register, polynomial reflected
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b, input logic short_type);
      logic [15:0] n;
      logic [4:0]  s;
      n = c >> 1;
      s = c[4:0] >> 1;
      if (short_type) begin
         if (c[0] ^ b) begin
            s = s ^ CRC_POLY5;
         end
         n = {11'h000, s};
      end else if (c[0] ^ b) begin
         n = n ^ CRC_POLY16;
      end
      return n;
   endfunction

   function automatic logic [11:0] byte_addr(input logic [7:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // registers

   logic [13:0]          tfc_q;
   logic [31:0]          tcc_q;
   logic [2:0]           rate_q;
   logic [CNT_WIDTH-1:0] count_q;
   logic                 go_q;
   logic                 no_data_err_q;
   logic [31:0]          prdata_q;
   logic                 pready_q;
   logic                 pslverr_q;
   nfctx_state_type      state_q;
   logic [7:0]           shreg_q;
   logic [3:0]           bit_idx_q;
   logic [3:0]           bit_end_q;
   logic                 par_q;
   logic [CNT_WIDTH-1:0] left_q;
   logic                 first_q;
   logic [15:0]          crc_q;
   logic [4:0]           crc_cnt_q;
   logic                 data_ready_q;
   logic                 enc_bit_q;
   logic                 enc_bit_valid_q;
   logic [1:0]           enc_symbol_q;
   logic                 enc_symbol_valid_q;
   logic                 frame_done_q;
   logic [2:0]           rate_active_q;
   logic [15:0]          div_q;
   logic                 tick_q;

   ////////////////////////////////////////////////////////////////////////////
   // bus decode

   wire        sel_tfc   = (paddr == byte_addr(IDX_TX_FRAME_CONFIG));
   wire        sel_tcc   = (paddr == byte_addr(IDX_TX_CHECKSUM_CONFIG));
   wire        sel_rate  = (paddr == byte_addr(IDX_RECEIVE_RATE_CONFIG));
   wire        sel_fct   = (paddr == byte_addr(IDX_FRAME_CONTROL));
   wire        mapped    = sel_tfc | sel_tcc | sel_rate | sel_fct;
   wire        acc_start = psel & penable & ~pready_q;
   wire        wr_commit = psel & penable & pready_q & pwrite & mapped;
   wire        busy      = (state_q != ST_IDLE);

   logic [31:0] rd_value;
   always_comb begin
      rd_value = 32'h0000_0000;
      if (sel_tfc) begin
         rd_value = {18'h00000, tfc_q};                                  // see R21
      end else if (sel_tcc) begin
         rd_value = tcc_q & TCC_WMASK;                                   // see R21
      end else if (sel_rate) begin
         rd_value = {29'h00000000, rate_q};
      end else if (sel_fct) begin
         rd_value[FCT_COUNT_LSB +: CNT_WIDTH] = count_q;
         rd_value[FCT_BUSY] = busy;
         rd_value[FCT_NO_DATA_ERR] = no_data_err_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // configuration fields

   wire       final_parity_invert      = tfc_q[TFC_FINAL_PARITY_INVERT];
   wire       parity_odd               = tfc_q[TFC_PARITY_TYPE];
   wire       parity_en                = tfc_q[TFC_PARITY_ENABLE];
   wire       data_en                  = tfc_q[TFC_DATA_ENABLE];
   wire [1:0] stop_sel                 = tfc_q[TFC_STOP_LSB +: 2];
   wire [1:0] start_sel                = tfc_q[TFC_START_LSB +: 2];
   wire [2:0] last_bits                = tfc_q[TFC_LAST_BITS_LSB +: 3];
   wire [2:0] first_bits               = tfc_q[TFC_FIRST_BITS_LSB +: 3];
   wire [15:0] preset_value            = tcc_q[TCC_PRESET_VALUE_LSB +: 16];     // see R10
   wire       checksum_skip_first_byte = tcc_q[TCC_SKIP_FIRST_BYTE];
   wire [2:0] preset_sel               = tcc_q[TCC_PRESET_SEL_LSB +: 3];
   wire       crc_short                = tcc_q[TCC_SHORT_TYPE];                 // see R14
   wire       checksum_complement      = tcc_q[TCC_COMPLEMENT];
   wire       crc_en                   = tcc_q[TCC_ENABLE];

   wire [15:0] preset_full = preset_of(preset_sel, preset_value);              // see R12
   wire [15:0] crc_init    = crc_short ? {8'h00, preset_full[7:0]} : preset_full; // see R13
   wire [4:0]  crc_len     = crc_short ? CRC_LEN5 : CRC_LEN16;                  // see R14

   wire        last_byte   = (left_q == CNT_WIDTH'(1));
   wire        no_data     = data_en && (count_q == '0);                       // see R4
   wire nfctx_state_type after_stop  = ST_DONE;
   wire nfctx_state_type to_stop     = (stop_sel != 2'b00) ? ST_STOP : after_stop; // see R6
   wire nfctx_state_type after_data  = crc_en ? ST_CRC : to_stop;                  // see R20
   wire nfctx_state_type after_start = data_en ? ST_LOAD : to_stop;                // see R5
   wire nfctx_state_type after_go    = (start_sel != 2'b00) ? ST_START : after_start; // see R7
   wire nfctx_state_type after_byte  = last_byte ? after_data : ST_LOAD;

   wire [3:0] win_start = (first_q && first_bits != 3'h0) ? (4'h8 - {1'b0, first_bits}) : 4'h0; // see R9
   wire [3:0] win_end   = (last_byte && last_bits != 3'h0) ? {1'b0, last_bits} : 4'h8;          // see R8
   wire       take_byte = data_valid & data_ready_q;
   wire       cur_bit   = shreg_q[bit_idx_q[2:0]];
   wire       crc_hold  = first_q & checksum_skip_first_byte;                                  // see R11
   wire       par_out   = par_q ^ (last_byte & final_parity_invert);                           // see R1

   ////////////////////////////////////////////////////////////////////////////
   // apb slave: one wait state

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= acc_start;
         pslverr_q <= acc_start & ~mapped;
         if (acc_start) begin
            prdata_q <= rd_value;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tfc_q   <= TFC_RESET;
         tcc_q   <= TCC_RESET;
         count_q <= FCT_COUNT_RESET;
      end else if (wr_commit) begin
         if (sel_tfc) begin
            tfc_q <= pwdata[TFC_WIDTH-1:0];                            // see R21
         end
         if (sel_tcc) begin
            tcc_q <= pwdata & TCC_WMASK;                               // see R21
         end
         if (sel_fct) begin
            count_q <= pwdata[FCT_COUNT_LSB +: CNT_WIDTH];
         end
      end
   end

   // hardware detection wins over a software write in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rate_q <= RATE_RESET;
      end else if (mode_detect_enable && mode_detect_valid) begin
         rate_q <= mode_detect_rate;                                   // see R19
      end else if (wr_commit && sel_rate) begin
         rate_q <= pwdata[2:0];                                        // see R17
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rate_active_q <= RATE_RESET;
      end else begin
         rate_active_q <= reader_mode ? rate_q : {1'b1, rate_q[1:0]};  // see R18
      end
   end

   wire err_set = go_q && !busy && no_data;
   wire err_clr = wr_commit && sel_fct && pwdata[FCT_NO_DATA_ERR];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         go_q          <= 1'b0;
         no_data_err_q <= 1'b0;
      end else begin
         go_q          <= wr_commit && sel_fct && pwdata[FCT_GO] && !busy;
         no_data_err_q <= err_set | (no_data_err_q & ~err_clr);        // see R4
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bit-rate enable

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q  <= 16'h0000;
         tick_q <= 1'b0;
      end else if (div_q == 16'(BIT_DIV - 1)) begin
         div_q  <= 16'h0000;
         tick_q <= 1'b1;
      end else begin
         div_q  <= div_q + 16'h0001;
         tick_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // frame sequencer

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q            <= ST_IDLE;
         shreg_q            <= 8'h00;
         bit_idx_q          <= 4'h0;
         bit_end_q          <= 4'h0;
         par_q              <= 1'b0;
         left_q             <= '0;
         first_q            <= 1'b0;
         crc_q              <= 16'h0000;
         crc_cnt_q          <= 5'h00;
         data_ready_q       <= 1'b0;
         enc_bit_q          <= 1'b0;
         enc_bit_valid_q    <= 1'b0;
         enc_symbol_q       <= 2'b00;
         enc_symbol_valid_q <= 1'b0;
         frame_done_q       <= 1'b0;
      end else begin
         enc_bit_valid_q    <= 1'b0;
         enc_symbol_valid_q <= 1'b0;
         frame_done_q       <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (go_q && !no_data) begin
                  left_q  <= count_q;
                  first_q <= 1'b1;
                  crc_cnt_q <= 5'h00;
                  crc_q   <= crc_init;                                  // see R12
                  state_q <= after_go;
               end
            end
            ST_START: begin
               if (tick_q) begin
                  enc_symbol_q       <= start_sel - 2'b01;              // see R7
                  enc_symbol_valid_q <= 1'b1;
                  state_q            <= after_start;
               end
            end
            ST_LOAD: begin
               data_ready_q <= ~take_byte;
               if (take_byte) begin
                  shreg_q   <= data_byte;
                  bit_idx_q <= win_start;                               // see R9
                  bit_end_q <= win_end;                                 // see R8
                  par_q     <= parity_odd;                              // see R2
                  state_q   <= ST_DATA;
               end
            end
            ST_DATA: begin
               if (tick_q) begin
                  enc_bit_q       <= cur_bit;                           // see R5
                  enc_bit_valid_q <= 1'b1;
                  par_q           <= par_q ^ cur_bit;                   // see R2
                  if (crc_en && !crc_hold) begin
                     crc_q <= crc_step(crc_q, cur_bit, crc_short);      // see R16
                  end
                  bit_idx_q <= bit_idx_q + 4'h1;
                  if (bit_idx_q + 4'h1 >= bit_end_q) begin
                     if (parity_en) begin
                        state_q <= ST_PARITY;                           // see R3
                     end else begin
                        left_q  <= left_q - CNT_WIDTH'(1);
                        first_q <= 1'b0;
                        state_q <= after_byte;
                     end
                  end
               end
            end
            ST_PARITY: begin
               if (tick_q) begin
                  enc_bit_q       <= par_out;                           // see R1
                  enc_bit_valid_q <= 1'b1;
                  left_q          <= left_q - CNT_WIDTH'(1);
                  first_q         <= 1'b0;
                  state_q         <= after_byte;                        // see R3
               end
            end
            ST_CRC: begin
               if (tick_q) begin
                  enc_bit_q       <= crc_q[crc_cnt_q[3:0]] ^ checksum_complement; // see R15
                  enc_bit_valid_q <= 1'b1;
                  crc_cnt_q       <= crc_cnt_q + 5'h01;
                  if (crc_cnt_q + 5'h01 == crc_len) begin
                     state_q <= to_stop;                                // see R20
                  end
               end
            end
            ST_STOP: begin
               if (tick_q) begin
                  enc_symbol_q       <= stop_sel;                       // see R6
                  enc_symbol_valid_q <= 1'b1;
                  state_q            <= after_stop;
               end
            end
            ST_DONE: begin
               frame_done_q <= 1'b1;
               state_q      <= ST_IDLE;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign prdata              = prdata_q;
   assign pready              = pready_q;
   assign pslverr             = pslverr_q;
   assign data_ready          = data_ready_q;
   assign enc_bit             = enc_bit_q;
   assign enc_bit_valid       = enc_bit_valid_q;
   assign enc_symbol          = enc_symbol_q;
   assign enc_symbol_valid    = enc_symbol_valid_q;
   assign frame_done          = frame_done_q;
   assign receive_rate_active = rate_active_q;

endmodule

// File: tb/nfctx_asserts.sv
`timescale 1ns/1ps
module nfctx_asserts
   import nfctx_pkg::*;
#(
   parameter int BIT_DIV = BIT_DIV_DEFAULT
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        data_valid,
   input wire logic        data_ready,
   input wire logic        enc_bit_valid,
   input wire logic        enc_symbol_valid,
   input wire logic        frame_done,
   input wire logic        reader_mode,
   input wire logic        mode_detect_enable,
   input wire logic        mode_detect_valid,
   input wire logic [2:0]  mode_detect_rate,
   input wire logic [2:0]  receive_rate_active
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_access; psel && penable && !pready; endsequence
   sequence s_detect; mode_detect_enable && mode_detect_valid && reader_mode; endsequence
   property p_answer; s_access |=> pready; endproperty
   property p_pulse; pready |=> !pready; endproperty
   property p_err; pready && pslverr |-> prdata == 32'h0; endproperty
   property p_bit_gap; BIT_DIV > 1 && enc_bit_valid |=> !(enc_bit_valid || enc_symbol_valid); endproperty
   property p_sym_gap; BIT_DIV > 1 && enc_symbol_valid |=> !enc_symbol_valid; endproperty
   property p_done; frame_done |-> $past(enc_bit_valid || enc_symbol_valid); endproperty
   property p_take; data_valid && data_ready |=> !data_ready; endproperty
   property p_card; !reader_mode && $past(!reader_mode) && $past(presetn, 2) |-> receive_rate_active[2]; endproperty
   property p_detect;
      logic [2:0] r;
      (s_detect, r = mode_detect_rate) ##1 reader_mode [*2] |-> receive_rate_active == r;
   endproperty
   a_answer: assert property (p_answer) else $error("access not answered");
   a_pulse: assert property (p_pulse) else $error("pready too long");
   a_err: assert property (p_err) else $error("refused read data not zero");
   a_bit_gap: assert property (p_bit_gap) else $error("bits too close");
   a_sym_gap: assert property (p_sym_gap) else $error("symbols too close");
   a_done: assert property (p_done) else $error("frame end without emission");
   a_take: assert property (p_take) else $error("ready held after take");
   a_card: assert property (p_card) else $error("rate msb not forced");
   a_detect: assert property (p_detect) else $error("detector rate lost");
endmodule
bind nfctx_encoder nfctx_asserts #(.BIT_DIV(BIT_DIV)) u_nfctx_asserts (.pclk, .presetn, .psel, .penable, .prdata,
   .pready, .pslverr, .data_valid, .data_ready, .enc_bit_valid, .enc_symbol_valid, .frame_done, .reader_mode,
   .mode_detect_enable, .mode_detect_valid, .mode_detect_rate, .receive_rate_active);

// File: tb/nfctx_partner.sv
`timescale 1ns/1ps
module nfctx_partner (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        clr,
   input wire logic        slow,
   input wire logic [31:0] bytes,
   input wire logic        data_ready,
   input wire logic        enc_bit,
   input wire logic        enc_bit_valid,
   input wire logic [1:0]  enc_symbol,
   input wire logic        enc_symbol_valid,
   output logic [7:0]      data_byte,
   output logic            data_valid,
   output logic [63:0]     bits,
   output logic [7:0]      nbits,
   output logic [3:0]      syms,
   output logic [1:0]      nsyms
);
   logic [1:0] idx_q;
   logic       dly_q;
   // idle bus shows the inverse so a stale byte never matches
   assign data_byte = data_valid ? bytes[8*idx_q +: 8] : ~bytes[8*idx_q +: 8];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn || clr) begin
         {idx_q, dly_q, data_valid, bits, nbits, syms, nsyms} <= '0;
      end else begin
         dly_q <= ~dly_q;
         if (data_valid && data_ready) begin
            data_valid <= 1'b0;
            idx_q <= idx_q + 2'h1;
         end else if (data_ready && (!slow || dly_q)) begin
            data_valid <= 1'b1;
         end
         if (enc_bit_valid) begin
            bits[nbits[5:0]] <= enc_bit;
            nbits <= nbits + 8'h01;
         end
         if (enc_symbol_valid) begin
            syms[{nsyms[0], 1'b0} +: 2] <= enc_symbol;
            nsyms <= nsyms + 2'h1;
         end
      end
   end
endmodule

// File: tb/nfc_tx_frame_crc_config_tb.sv
`timescale 1ns/1ps
module nfc_tx_frame_crc_config_tb;
   import nfctx_pkg::*;
   localparam logic [11:0] A_TFC = {2'h0, IDX_TX_FRAME_CONFIG, 2'h0};
   localparam logic [11:0] A_TCC = {2'h0, IDX_TX_CHECKSUM_CONFIG, 2'h0};
   localparam logic [11:0] A_RRC = {2'h0, IDX_RECEIVE_RATE_CONFIG, 2'h0};
   localparam logic [11:0] A_FCT = {2'h0, IDX_FRAME_CONTROL, 2'h0};
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, data_valid, data_ready, enc_bit, enc_bit_valid;
   logic enc_symbol_valid, frame_done, reader_mode, mode_detect_enable, mode_detect_valid, clr, slow, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, bytes;
   logic [7:0]  data_byte, nbits;
   logic [1:0]  enc_symbol, nsyms;
   logic [2:0]  mode_detect_rate, receive_rate_active;
   logic [63:0] bits;
   logic [3:0]  syms;
   int failures, n_checks, cyc;
   nfctx_encoder #(.BIT_DIV(2)) u_nfctx_encoder (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .data_byte, .data_valid, .data_ready, .enc_bit, .enc_bit_valid, .enc_symbol,
      .enc_symbol_valid, .frame_done, .reader_mode, .mode_detect_enable, .mode_detect_valid, .mode_detect_rate,
      .receive_rate_active);
   nfctx_partner u_nfctx_partner (.pclk, .presetn, .clr, .slow, .bytes, .data_ready, .enc_bit, .enc_bit_valid,
      .enc_symbol, .enc_symbol_valid, .data_byte, .data_valid, .bits, .nbits, .syms, .nsyms);
   ////////////////////////////////////////////////////////////////////////////
   task chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask
   task conclude;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk("rdata", 64'(rd), 64'(exp));
   endtask
   task frame(input logic [13:0] t, input logic [31:0] c, input int n, input logic [31:0] b);
      logic [63:0] e;
      logic [15:0] crc;
      logic [3:0]  es;
      logic        p, x;
      int m, lo, hi, ns;
      e = '0; es = '0; m = 0; ns = 0;
      case (c[5:3])
         3'h1: crc = 16'h6363;
         3'h2: crc = 16'ha671;
         3'h3: crc = 16'hffff;
         3'h4: crc = 16'h0012;
         3'h5: crc = 16'he012;
         3'h7: crc = c[31:16];
         default: crc = 16'h0000;
      endcase
      if (c[2]) crc = {11'h0, crc[4:0]};
      for (int i = 0; i < (t[10] ? n : 0); i++) begin
         lo = (i == 0 && t[2:0] != 0) ? 8 - t[2:0] : 0;
         hi = (i == n - 1 && t[5:3] != 0) ? t[5:3] - 1 : 7;
         p = t[12] ^ (t[13] && i == n - 1);
         for (int j = lo; j <= hi; j++) begin
            x = b[8*i+j];
            e[m++] = x;
            p ^= x;
            if (!(c[6] && i == 0)) begin
               crc = (crc >> 1) ^ ((crc[0] ^ x) ? (c[2] ? 16'h0012 : 16'h8408) : 16'h0);
            end
         end
         if (t[11]) e[m++] = p;
      end
      if (c[0] && t[10]) for (int j = 0; j < (c[2] ? 5 : 16); j++) e[m++] = crc[j] ^ c[1];
      if (t[7:6] != 0) es[2*ns++ +: 2] = t[7:6] - 2'h1;
      if (t[9:8] != 0) es[2*ns++ +: 2] = t[9:8];
      apb(1'b1, A_TFC, {18'h0, t});
      apb(1'b1, A_TCC, c);
      bytes <= b;
      clr <= 1'b1;
      @(posedge pclk);
      clr <= 1'b0;
      apb(1'b1, A_FCT, (n << 16) | 1);
      do @(posedge pclk); while (frame_done !== 1'b1);
      chk("nbits", 64'(nbits), 64'(m));
      chk("bits", bits, e);
      chk("syms", {nsyms, syms}, {2'(ns), es});
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         conclude();
      end
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, clr, slow, bytes} = '0;
      {reader_mode, mode_detect_enable, mode_detect_valid, mode_detect_rate} = 6'h20;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(A_TFC, 32'h0);
      rdchk(A_TCC, 32'h0);
      rdchk(A_RRC, 32'h0);
      apb(1'b1, A_TFC, 32'hffffffff);
      rdchk(A_TFC, 32'h00003fff);
      apb(1'b1, A_TCC, 32'hffffffff);
      rdchk(A_TCC, 32'hffff007f);
      apb(1'b1, A_RRC, 32'hffffffff);
      rdchk(A_RRC, 32'h7);
      apb(1'b0, 12'h0fc, 32'h0);
      chk("unmapped", {rd, 31'h0, er}, 64'h1);
      apb(1'b0, 12'h061, 32'h0);
      chk("misaligned", 64'(er), 64'h1);
      frame(14'h3f40, 32'h0, 1, 32'h000000a5);
      slow <= 1'b1;
      frame(14'h0d80, 32'h0, 3, 32'h00f00f81);
      slow <= 1'b0;
      frame(14'h0e2b, 32'h0, 2, 32'h0000b7e4);
      for (int s = 0; s < 8; s++) frame(14'h0400, {16'h1234, 9'h0, s == 7, 3'(s), 1'b0, s[0], 1'b1},
         s == 7 ? 2 : 1, 32'h0000c35a);
      for (int s = 1; s < 6; s++) frame(14'h0400, {26'h0, 3'(s), 3'h5}, 1, 32'h96);
      frame(14'h02c0, 32'h1, 1, 32'h5a);
      apb(1'b1, A_TFC, 32'h0400);
      apb(1'b1, A_FCT, 32'h1);
      rdchk(A_FCT, 32'h4);
      apb(1'b1, A_FCT, 32'h4);
      rdchk(A_FCT, 32'h0);
      apb(1'b1, A_RRC, 32'h5);
      repeat (3) @(posedge pclk);
      chk("rate", 64'(receive_rate_active), 64'h5);
      reader_mode <= 1'b0;
      apb(1'b1, A_RRC, 32'h2);
      repeat (3) @(posedge pclk);
      chk("card rate", 64'(receive_rate_active), 64'h6);
      reader_mode <= 1'b1;
      {mode_detect_valid, mode_detect_rate} <= 4'hc;
      @(posedge pclk);
      {mode_detect_enable, mode_detect_valid, mode_detect_rate} <= 5'h1e;
      @(posedge pclk);
      mode_detect_valid <= 1'b0;
      rdchk(A_RRC, 32'h6);
      conclude();
   end
endmodule
